// ===== src/prfr_pkg.sv
package prfr_pkg;

  // command codes of the register bank
  localparam logic [7:0] CMD_THD_LOW  = 8'h03;
  localparam logic [7:0] CMD_THD_HIGH = 8'h04;
  localparam logic [7:0] CMD_CANCEL   = 8'h05;
  localparam logic [7:0] CMD_RESULT   = 8'hf8;
  localparam logic [7:0] CMD_FLAGS    = 8'hf9;

  // register widths and field layout
  localparam int         REG_WIDTH    = 16;
  localparam int         CANCEL_WIDTH = 12;
  localparam int         CANCEL_MSB   = 11;
  localparam int         FLAG_SUN_POS  = 12;
  localparam int         FLAG_HIGH_POS = 9;
  localparam int         FLAG_LOW_POS  = 8;

  // reset values
  localparam logic [15:0] RST_THD_LOW  = 16'h0000;
  localparam logic [15:0] RST_THD_HIGH = 16'hffff;
  localparam logic [11:0] RST_CANCEL   = 12'h000;
  localparam logic [15:0] RST_RESULT   = 16'h0000;
  localparam logic [15:0] RST_RDATA    = 16'h0000;
  localparam logic [15:0] READ_ZERO    = 16'h0000;
  localparam logic [3:0]  CANCEL_PAD   = 4'h0;

  // one register access, taken in a single cycle
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  cmd;
    logic [15:0] wdata;
  } prfr_req_t;

  // sticky event flags
  typedef struct packed {
    logic sun;
    logic high;
    logic low;
  } prfr_flags_t;

endpackage

// ===== src/prfr_regs.sv
`timescale 1ns/1ps
`default_nettype none

module prfr_regs
(
  // clock and asynchronous reset
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  // register access from the host side, then the raw sample and sunlight inputs
  input  wire prfr_pkg::prfr_req_t regReq,
  input  wire logic [15:0]        rawCount,
  input  wire logic               rawValid,
  input  wire logic               sunlightEvent,
  // read answer and status, all registered
  output logic      [15:0]        rdData,
  output logic                    rdValid,
  output logic      [15:0]        proximityResult,
  output logic                    eventPending
);

  // register bank state
  logic [15:0]           lowThreshold_q;
  logic [15:0]           highThreshold_q;
  logic [11:0]           offsetCancel_q;
  logic [15:0]           result_q;
  prfr_pkg::prfr_flags_t flags_q;
  logic [15:0]           rdData_q;
  logic                  rdValid_q;
  logic                  eventPending_q;

  // next values, one per register
  logic [15:0]           lowThreshold_d;
  logic [15:0]           highThreshold_d;
  logic [11:0]           offsetCancel_d;
  logic [15:0]           result_d;
  prfr_pkg::prfr_flags_t flags_d;
  logic [15:0]           rdData_d;
  logic                  rdValid_d;
  logic                  eventPending_d;

  // sample path and flag helpers
  logic [15:0]           cancelWide;
  logic [15:0]           corrected;
  logic                  highHit;
  logic                  lowHit;
  logic                  flagsRead;

  // host writes to the two threshold registers
  always_comb
  begin
    lowThreshold_d  = lowThreshold_q;
    highThreshold_d = highThreshold_q;
    if (regReq.wr)
    begin
      unique case (regReq.cmd)
        prfr_pkg::CMD_THD_LOW:  lowThreshold_d  = regReq.wdata;
        // high threshold sits outside the rule set, but high events need it
        prfr_pkg::CMD_THD_HIGH: highThreshold_d = regReq.wdata;
        default:                ;
      endcase
    end
  end

  // thresholds reset wide open, so no crossing shows before the host sets them
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lowThreshold_q  <= prfr_pkg::RST_THD_LOW;
      highThreshold_q <= prfr_pkg::RST_THD_HIGH;
    end
    else
    begin
      lowThreshold_q  <= lowThreshold_d;
      highThreshold_q <= highThreshold_d;
    end
  end

  // reserved top nibble dropped, so a careless host cannot widen the offset
  always_comb
  begin
    offsetCancel_d = offsetCancel_q;
    if (regReq.wr && (regReq.cmd == prfr_pkg::CMD_CANCEL))
      offsetCancel_d = regReq.wdata[prfr_pkg::CANCEL_MSB:0];
  end

  // offset cancel register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      offsetCancel_q <= prfr_pkg::RST_CANCEL;
    else
      offsetCancel_q <= offsetCancel_d;
  end

  // offset correction on each new sample
  always_comb
  begin
    cancelWide = {prfr_pkg::CANCEL_PAD, offsetCancel_q};
    // saturate rather than wrap, a wrap would look like a very close target
    if (rawCount > cancelWide)
      corrected = rawCount - cancelWide;
    else
      corrected = prfr_pkg::RST_RESULT;
    result_d = rawValid ? corrected : result_q;
  end

  // result holds the last corrected sample
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      result_q <= prfr_pkg::RST_RESULT;
    else
      result_q <= result_d;
  end

  // strict compares on the corrected value, only while a sample is valid
  always_comb
  begin
    highHit = rawValid && (corrected > highThreshold_q);
    lowHit  = rawValid && (corrected < lowThreshold_q);
  end

  // sticky flags, cleared by reading the flag register; a new event wins
  always_comb
  begin
    // the read returns the old word, the clear lands on the same edge
    flagsRead    = regReq.rd && (regReq.cmd == prfr_pkg::CMD_FLAGS);
    flags_d.sun  = sunlightEvent || (flags_q.sun && !flagsRead);
    flags_d.high = highHit || (flags_q.high && !flagsRead);
    flags_d.low  = lowHit || (flags_q.low && !flagsRead);
  end

  // flag register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      flags_q <= '0;
    else
      flags_q <= flags_d;
  end

  // summary taken from the next flags, so it rises with them
  always_comb
  begin
    eventPending_d = flags_d.sun || flags_d.high || flags_d.low;
  end

  // pending summary register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      eventPending_q <= 1'b0;
    else
      eventPending_q <= eventPending_d;
  end

  // read mux, answered one cycle after the request
  always_comb
  begin
    rdData_d = rdData_q;
    if (regReq.rd)
    begin
      // reserved and unused bits of every word read as zero
      rdData_d = prfr_pkg::READ_ZERO;
      unique case (regReq.cmd)
        prfr_pkg::CMD_THD_LOW:  rdData_d = lowThreshold_q;
        prfr_pkg::CMD_THD_HIGH: rdData_d = highThreshold_q;
        prfr_pkg::CMD_CANCEL:   rdData_d = {prfr_pkg::CANCEL_PAD, offsetCancel_q};
        prfr_pkg::CMD_RESULT:   rdData_d = result_q;
        prfr_pkg::CMD_FLAGS:
        begin
          rdData_d[prfr_pkg::FLAG_SUN_POS]  = flags_q.sun;
          rdData_d[prfr_pkg::FLAG_HIGH_POS] = flags_q.high;
          rdData_d[prfr_pkg::FLAG_LOW_POS]  = flags_q.low;
        end
        default:                rdData_d = prfr_pkg::READ_ZERO; // unmapped reads zero
      endcase
    end
  end

  // read data holds until the next read answer
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rdData_q <= prfr_pkg::RST_RDATA;
    else
      rdData_q <= rdData_d;
  end

  // every read is answered, mapped or not, so the host never waits
  always_comb
  begin
    rdValid_d = regReq.rd;
  end

  // read answer strobe, one cycle wide
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rdValid_q <= 1'b0;
    else
      rdValid_q <= rdValid_d;
  end

  // outputs come straight from their flip-flops
  assign rdData          = rdData_q;
  assign rdValid         = rdValid_q;
  assign proximityResult = result_q;
  assign eventPending    = eventPending_q;

endmodule

`default_nettype wire

// ===== verif/prfr_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the register port, gap cycle between accesses
module prfr_host
(
  input  wire logic              ref_clk,
  output var prfr_pkg::prfr_req_t regReq
);
  initial regReq = '0;
  // reserved cancel bits kept low on every write
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(negedge ref_clk);
    regReq = '{w, !w, c, (c == prfr_pkg::CMD_CANCEL) ? {4'h0, d[11:0]} : d};
    @(negedge ref_clk);
    regReq = '0;
  endtask
endmodule
`default_nettype wire

// ===== verif/prfr_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module prfr_regs_chk
(
  input wire logic                ref_clk,
  input wire logic                nrst,
  input wire prfr_pkg::prfr_req_t regReq,
  input wire logic [15:0]         rawCount,
  input wire logic                rawValid,
  input wire logic                sunlightEvent,
  input wire logic [15:0]         rdData,
  input wire logic                rdValid,
  input wire logic [15:0]         proximityResult,
  input wire logic                eventPending
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // read answers come exactly one cycle late, and only then
  a_read_answer: assert property (regReq.rd |=> rdValid) else $error("no answer");
  a_no_stray: assert property (!regReq.rd |=> !rdValid) else $error("stray answer");
  a_result_read: assert property (regReq.rd && regReq.cmd == 8'hf8
    |=> rdData == $past(proximityResult)) else $error("result read differs");
  a_result_hold: assert property (!rawValid |=> $stable(proximityResult))
    else $error("result moved");
  a_cancel_pad: assert property (regReq.rd && regReq.cmd == 8'h05
    |=> rdData[15:12] == 4'h0) else $error("cancel pad set");
  a_zero_sat: assert property (rawValid && rawCount == 16'h0000
    |=> proximityResult == 16'h0000) else $error("no saturation");
  a_sun_pend: assert property (sunlightEvent |=> eventPending) else $error("sun lost");
  // no pending flag and no new event means the flag word reads all zero
  a_flags_idle: assert property (regReq.rd && regReq.cmd == 8'hf9 && !eventPending
    && !rawValid && !sunlightEvent |=> rdData == 16'h0000) else $error("stray flag");
  c_sun: cover property (sunlightEvent ##1 eventPending);
  c_low: cover property (rdValid && rdData[8]);
  c_high: cover property (rdValid && rdData[9]);
endmodule
bind prfr_regs prfr_regs_chk u_chk (.ref_clk, .nrst, .regReq, .rawCount, .rawValid,
  .sunlightEvent, .rdData, .rdValid, .proximityResult, .eventPending);
`default_nettype wire

// ===== verif/prfr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module prfr_regs_tb;
  logic ref_clk = 0, nrst = 0, rawValid = 0, sunlightEvent = 0, rdValid, eventPending;
  logic [15:0] rawCount = '0, rdData, proximityResult, q[$];
  logic [31:0] s;
  logic [11:0] c;
  int mismatches = 0, checked = 0;
  prfr_pkg::prfr_req_t regReq;
  always #4 ref_clk = ~ref_clk;
  prfr_host u_prfr_host (.ref_clk, .regReq);
  prfr_regs u_prfr_regs (.ref_clk, .nrst, .regReq, .rawCount, .rawValid, .sunlightEvent,
    .rdData, .rdValid, .proximityResult, .eventPending);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // corrected result, clamped at zero
  function automatic logic [15:0] sat(input logic [15:0] r);
    return (r > {4'h0, c}) ? r - {4'h0, c} : 16'h0000;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value rdData exp %h seen %h", exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    q.push_back(exp);
    u_prfr_host.acc(1'b0, cmd, 16'h0000);
  endtask
  task automatic smp(input logic [15:0] r, input logic sun);
    @(negedge ref_clk);
    rawCount = r;
    rawValid = 1'b1;
    sunlightEvent = sun;
    @(negedge ref_clk);
    rawValid = 1'b0;
    sunlightEvent = 1'b0;
  endtask
  task automatic close_out;
    if (q.size() != 0) mismatches++;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // answers are matched in issue order
  always @(negedge ref_clk) if (rdValid === 1'b1) chk(rdData, q.pop_front());
  initial
  begin
    s = lfsr(32'hd6ae);
    c = s[11:0];
    repeat (20) @(negedge ref_clk);
    nrst = 1'b1;
    rd(prfr_pkg::CMD_FLAGS, 16'h0000);
    u_prfr_host.acc(1'b1, prfr_pkg::CMD_CANCEL, s[15:0]);
    rd(prfr_pkg::CMD_CANCEL, {4'h0, c});
    smp(16'h1000, 1'b0);
    rd(prfr_pkg::CMD_RESULT, sat(16'h1000));
    smp(16'h0001, 1'b0);
    rd(prfr_pkg::CMD_RESULT, sat(16'h0001));
    smp(16'h0000, 1'b0);
    rd(prfr_pkg::CMD_RESULT, sat(16'h0000));
    u_prfr_host.acc(1'b1, prfr_pkg::CMD_THD_LOW, 16'h0050);
    rd(prfr_pkg::CMD_THD_LOW, 16'h0050);
    smp({4'h0, c} + 16'h0010, 1'b0);
    rd(prfr_pkg::CMD_FLAGS, 16'h0100);
    rd(prfr_pkg::CMD_FLAGS, 16'h0000);
    u_prfr_host.acc(1'b1, prfr_pkg::CMD_THD_HIGH, 16'h0200);
    smp({4'h0, c} + 16'h0300, 1'b1);
    rd(prfr_pkg::CMD_FLAGS, 16'h1200);
    rd(8'h77, 16'h0000);
    rd(prfr_pkg::CMD_RESULT, 16'h0300);
    // mid-run reset brings every register back to its reset value
    @(negedge ref_clk);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    rd(prfr_pkg::CMD_CANCEL, {prfr_pkg::CANCEL_PAD, prfr_pkg::RST_CANCEL});
    rd(prfr_pkg::CMD_THD_HIGH, prfr_pkg::RST_THD_HIGH);
    rd(prfr_pkg::CMD_RESULT, prfr_pkg::RST_RESULT);
    repeat (4) @(negedge ref_clk);
    close_out();
  end
endmodule
`default_nettype wire
